// [design/control_command_decoder.sv]
// control command decoder with tributary table and state block storage
`timescale 1ns/10ps
module control_command_decoder #(
  parameter int NT = ctl_cmd_pkg::NUM_TRIB,
  parameter int BD = ctl_cmd_pkg::TSB_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // command from host
  input wire logic cmd_valid,
  input wire ctl_cmd_pkg::ctl_cmd_t cmd,
  // state block access from link logic
  input wire logic tsb_wr_en,
  input wire logic [ctl_cmd_pkg::SLOT_W-1:0] tsb_slot,
  input wire logic [5:0] tsb_addr,
  input wire logic [7:0] tsb_wr_data,
  output logic [7:0] tsb_rd_data,
  // status selection
  input wire logic [ctl_cmd_pkg::SLOT_W-1:0] status_slot,
  output ctl_cmd_pkg::trib_status_t status_r,
  // global status
  output logic gss_present_r,
  output logic registers_owned_r,
  output logic proc_error_r,
  output logic cmd_done_r,
  output logic table_full_r
);
  import ctl_cmd_pkg::*;

  // ------------------------------------------------------------
  // tributary table
  // ------------------------------------------------------------
  localparam int MAW = $clog2(NT * BD);
  logic [NT-1:0] est_r; // slot in use
  logic [7:0] addr_r [NT]; // tributary address per slot
  logic [NT-1:0] pool_r; // shared pool enabled
  logic [NT-1:0] latch_r; // polling latched by host
  poll_state_t poll_r [NT];
  logic [7:0] quota_r [NT];
  logic [NT-1:0] hit; // slot matches command address
  logic [NT-1:0] free_sel; // lowest free slot, one-hot
  logic any_hit;
  logic any_free;
  logic [8:0] quota_sum [NT];
  logic [NT-1:0] sat;

  // match and free-slot search, one entry per generate step
  genvar g;
  generate
    for (g = 0; g < NT; g++)
    begin : g_match
      assign hit[g] = est_r[g] && (addr_r[g] == cmd.tributary_address_byte);
      if (g == 0)
      begin : g_first
        assign free_sel[g] = !est_r[g];
      end
      else
      begin : g_rest
        assign free_sel[g] = !est_r[g] && (&est_r[g-1:0]);
      end
      assign quota_sum[g] = {1'b0, quota_r[g]} + {1'b0, cmd.command_parameter_byte};
      // unlimited use is the parameter of all ones, not a saturation
      assign sat[g] = (cmd.command_parameter_byte != QUOTA_LIMIT) &&
                      (quota_sum[g] >= {1'b0, QUOTA_LIMIT});
    end
  endgenerate
  assign any_hit = |hit;
  assign any_free = |free_sel;

  // decoded command
  logic is_est;
  logic is_null;
  logic [NT-1:0] tgt; // slot acted on by modifiers
  assign is_null = cmd_valid && (cmd.request_key == KEY_NULL);
  assign is_est = cmd_valid && (cmd.request_key == KEY_ESTABLISH);
  // modifiers follow establish into the freshly taken slot
  assign tgt = any_hit ? hit : (is_est ? free_sel : '0);

  // ------------------------------------------------------------
  // slot allocation
  // ------------------------------------------------------------
  // re-establish of a known address keeps its slot
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      est_r <= '0;
      for (int i = 0; i < NT; i++)
      begin
        addr_r[i] <= 8'h00;
      end
    end
    else if (is_est && !any_hit && any_free)
    begin
      for (int i = 0; i < NT; i++)
      begin
        if (free_sel[i])
        begin
          est_r[i] <= 1'b1;
          addr_r[i] <= cmd.tributary_address_byte;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // shared pool control and quota
  // ------------------------------------------------------------
  // modifier bits 2 and 3 are never decoded
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pool_r <= '0;
      for (int i = 0; i < NT; i++)
      begin
        quota_r[i] <= QUOTA_RST;
      end
    end
    else if (cmd_valid)
    begin
      for (int i = 0; i < NT; i++)
      begin
        if (tgt[i] && cmd.command_modifier_byte[MOD_POOL_DIS])
        begin
          // disable wins if both set
          pool_r[i] <= 1'b0;
          quota_r[i] <= QUOTA_RST;
        end
        else if (tgt[i] && cmd.command_modifier_byte[MOD_POOL_EN])
        begin
          pool_r[i] <= 1'b1;
          // all ones asks for unlimited use, so it is kept whole, never wrapped
          quota_r[i] <= (cmd.command_parameter_byte == QUOTA_LIMIT) ? QUOTA_LIMIT :
                        (sat[i] ? QUOTA_SAT : quota_sum[i][7:0]);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // polling state
  // ------------------------------------------------------------
  // latch wins over unlatch when both are set
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      latch_r <= '0;
      for (int i = 0; i < NT; i++)
      begin
        poll_r[i] <= POLL_ACTIVE;
      end
    end
    else if (cmd_valid)
    begin
      for (int i = 0; i < NT; i++)
      begin
        if (tgt[i] && cmd.command_modifier_byte[MOD_LATCH])
        begin
          latch_r[i] <= 1'b1;
          poll_r[i] <= poll_state_t'(cmd.command_parameter_byte[1:0]);
        end
        else if (tgt[i] && cmd.command_modifier_byte[MOD_UNLATCH])
        begin
          latch_r[i] <= 1'b0;
          poll_r[i] <= POLL_ACTIVE;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // global status and completion
  // ------------------------------------------------------------
  // global block exists while any slot is in use
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gss_present_r <= 1'b0;
      table_full_r <= 1'b0;
    end
    else
    begin
      gss_present_r <= |est_r;
      table_full_r <= &est_r;
    end
  end

  // ownership returns to the device after any accepted command
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      registers_owned_r <= 1'b1;
      cmd_done_r <= 1'b0;
      proc_error_r <= 1'b0;
    end
    else
    begin
      registers_owned_r <= 1'b1;
      cmd_done_r <= cmd_valid;
      // error for saturating quota or full table on establish
      proc_error_r <= cmd_valid && ((|(tgt & sat) &&
                      cmd.command_modifier_byte[MOD_POOL_EN] &&
                      !cmd.command_modifier_byte[MOD_POOL_DIS]) ||
                      (is_est && !any_hit && !any_free));
    end
  end

  // selected slot status, registered for the port
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      status_r <= '0;
    end
    else if (status_slot < SLOT_W'(NT))
    begin
      status_r <= {est_r[status_slot], pool_r[status_slot], latch_r[status_slot],
                   poll_r[status_slot], quota_r[status_slot]};
    end
    else
    begin
      status_r <= '0;
    end
  end

  // ------------------------------------------------------------
  // state block storage
  // ------------------------------------------------------------
  logic [MAW-1:0] mem_addr;
  assign mem_addr = MAW'(tsb_slot * BD) + MAW'(tsb_addr);
  state_block_mem #(
    .DEPTH(NT * BD),
    .AW(MAW)
  ) u_mem (
    .clk(clk),
    .wr_en(tsb_wr_en && (tsb_slot < SLOT_W'(NT))),
    .wr_addr(mem_addr),
    .wr_data(tsb_wr_data),
    .rd_addr(mem_addr),
    .rd_data(tsb_rd_data)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_disable_clears: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd_valid && hit[0] && cmd.command_modifier_byte[MOD_POOL_DIS]) |=> quota_r[0] == QUOTA_RST)
    else $error("quota not cleared");
  a_disable_pool: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd_valid && hit[0] && cmd.command_modifier_byte[MOD_POOL_DIS]) |=> !pool_r[0])
    else $error("pool not disabled");
  a_unlatch_active: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd_valid && hit[0] && cmd.command_modifier_byte[MOD_UNLATCH] &&
     !cmd.command_modifier_byte[MOD_LATCH]) |=> (poll_r[0] == POLL_ACTIVE && !latch_r[0]))
    else $error("unlatch failed");
  a_latch_state: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd_valid && hit[0] && cmd.command_modifier_byte[MOD_LATCH]) |=>
    (poll_r[0] == $past(cmd.command_parameter_byte[1:0]) && latch_r[0]))
    else $error("latch state wrong");
  a_null_owned: assert property (@(posedge clk) disable iff (sys_rst)
    is_null |=> (registers_owned_r && cmd_done_r))
    else $error("null command not completed");
  a_est_alloc: assert property (@(posedge clk) disable iff (sys_rst)
    (is_est && !any_hit && any_free) |=> ($countones(est_r) == $countones($past(est_r)) + 1))
    else $error("establish did not allocate");
  a_gss_follow: assert property (@(posedge clk) disable iff (sys_rst)
    gss_present_r == $past(|est_r))
    else $error("global block missing");
  a_quota_sat: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd_valid && hit[0] && sat[0] && cmd.command_modifier_byte[MOD_POOL_EN] &&
     !cmd.command_modifier_byte[MOD_POOL_DIS]) |=> (quota_r[0] == QUOTA_SAT && proc_error_r))
    else $error("quota not saturated");
  a_quota_unlimited: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd_valid && hit[0] && (cmd.command_parameter_byte == QUOTA_LIMIT) &&
     cmd.command_modifier_byte[MOD_POOL_EN] && !cmd.command_modifier_byte[MOD_POOL_DIS]) |=>
    (quota_r[0] == QUOTA_LIMIT && !proc_error_r))
    else $error("unlimited quota lost");
  a_est_modifier: assert property (@(posedge clk) disable iff (sys_rst)
    (is_est && !any_hit && free_sel[0] && cmd.command_modifier_byte[MOD_POOL_EN] &&
     !cmd.command_modifier_byte[MOD_POOL_DIS]) |=> pool_r[0])
    else $error("modifier lost on establish");
endmodule : control_command_decoder

// [inc/ctl_cmd_pkg.sv]
// package of constants and types for the control command decoder
package ctl_cmd_pkg;
  // ------------------------------------------------------------
  // command fields
  // ------------------------------------------------------------
  localparam int NUM_TRIB = 12;
  localparam int TSB_DEPTH = 64;
  localparam int SLOT_W = 4;
  localparam int MOD_POOL_EN = 0;
  localparam int MOD_POOL_DIS = 1;
  localparam int MOD_UNLATCH = 4;
  localparam int MOD_LATCH = 5;
  localparam logic [7:0] KEY_NULL = 8'h00;
  localparam logic [7:0] KEY_ESTABLISH = 8'h01;
  localparam logic [7:0] QUOTA_LIMIT = 8'hff;
  localparam logic [7:0] QUOTA_SAT = 8'hfe;
  localparam logic [7:0] QUOTA_RST = 8'h00;
  localparam logic [5:0] TSB_ADDR_RST = 6'h00;

  // polling state encoding
  typedef enum logic [1:0]
  {
    POLL_ACTIVE = 2'b00,
    POLL_INACTIVE = 2'b01,
    POLL_UNRESP = 2'b10,
    POLL_DEAD = 2'b11
  } poll_state_t;

  // one control command as written by the host
  typedef struct packed
  {
    logic [7:0] command_modifier_byte;
    logic [7:0] request_key;
    logic [7:0] tributary_address_byte;
    logic [7:0] command_parameter_byte;
  } ctl_cmd_t;

  // per-tributary status as shown on the ports
  typedef struct packed
  {
    logic established;
    logic pool_enabled;
    logic latched;
    poll_state_t poll_state;
    logic [7:0] quota;
  } trib_status_t;
endpackage : ctl_cmd_pkg

// [design/state_block_mem.sv]
// storage for the per-station state blocks, registered read
`timescale 1ns/10ps
module state_block_mem #(
  parameter int DEPTH = 768,
  parameter int AW = 10
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read port
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  // plain array, no reset so it maps to ram
  logic [7:0] mem [DEPTH];

  // write side
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read side
  always_ff @(posedge clk)
  begin
    rd_data <= mem[rd_addr];
  end
endmodule : state_block_mem

// [tb/testbench.sv]
// self-checking testbench for the control command decoder
`timescale 1ns/10ps
module testbench;
  import ctl_cmd_pkg::*;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  ctl_cmd_t cmd = '0;
  logic tsb_wr_en = 1'b0;
  logic [SLOT_W-1:0] tsb_slot = '0;
  logic [5:0] tsb_addr = '0;
  logic [7:0] tsb_wr_data = '0;
  logic [7:0] tsb_rd_data;
  logic [SLOT_W-1:0] status_slot = '0;
  trib_status_t status_r;
  logic gss_present_r, registers_owned_r, proc_error_r, cmd_done_r, table_full_r;
  int bad_count = 0; // mismatches seen
  int num_checks = 0; // comparisons made
  logic err; // error pulse taken with the done pulse

  // 50 MHz clock
  always #10 clk = ~clk;

  control_command_decoder i_dut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd(cmd), .tsb_wr_en(tsb_wr_en), .tsb_slot(tsb_slot), .tsb_addr(tsb_addr),
    .tsb_wr_data(tsb_wr_data), .tsb_rd_data(tsb_rd_data), .status_slot(status_slot),
    .status_r(status_r), .gss_present_r(gss_present_r),
    .registers_owned_r(registers_owned_r), .proc_error_r(proc_error_r),
    .cmd_done_r(cmd_done_r), .table_full_r(table_full_r));

  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  // compare one value, four-state exact
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one command; done and error pulses stand one cycle, so look right after the edge
  task automatic send(input logic [7:0] mods, key, addr, par);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= {mods, key, addr, par};
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    chk("done", 16'h0001, {15'h0, cmd_done_r});
    chk("owned", 16'h0001, {15'h0, registers_owned_r});
    err = proc_error_r;
  endtask : send

  // status is registered one cycle after the slot select lands
  task automatic status(input logic [SLOT_W-1:0] slot, input logic [12:0] exp);
    @(posedge clk);
    status_slot <= slot;
    @(posedge clk);
    @(posedge clk);
    #1;
    chk("status", {3'h0, exp}, {3'h0, status_r});
  endtask : status

  // state block write pulse
  task automatic tsb_wr(input logic [SLOT_W-1:0] s, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    tsb_wr_en <= 1'b1;
    tsb_slot <= s;
    tsb_addr <= a;
    tsb_wr_data <= d;
    @(posedge clk);
    tsb_wr_en <= 1'b0;
  endtask : tsb_wr

  // state block read, data one cycle after the address
  task automatic tsb_rd(input logic [SLOT_W-1:0] s, input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    tsb_slot <= s;
    tsb_addr <= a;
    @(posedge clk);
    #1;
    chk("state block", {8'h00, e}, {8'h00, tsb_rd_data});
  endtask : tsb_rd

  // verdict, the single end of the run
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  // ------------------------------------------------------------
  // watchdog: a hang counts as a mismatch
  // ------------------------------------------------------------
  initial
  begin
    #1000000;
    bad_count++;
    conclude();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("gss", 16'h0000, {15'h0, gss_present_r});
    chk("full", 16'h0000, {15'h0, table_full_r});
    status(4'h0, 13'h0000);
    // modifiers for an address not yet known must be dropped
    send(8'h21, KEY_NULL, 8'h05, 8'h07);
    chk("err", 16'h0000, {15'h0, err});
    // establish with pool enable in the same command
    send(8'h01, KEY_ESTABLISH, 8'h01, 8'h05);
    status(4'h0, {3'b110, POLL_ACTIVE, 8'h05});
    chk("gss", 16'h0001, {15'h0, gss_present_r});
    send(8'h01, KEY_NULL, 8'h01, 8'hf0);
    status(4'h0, {3'b110, POLL_ACTIVE, 8'hf5});
    // sum lands exactly on the limit, so it saturates with an error
    send(8'h01, KEY_NULL, 8'h01, 8'h0a);
    chk("err", 16'h0001, {15'h0, err});
    status(4'h0, {3'b110, POLL_ACTIVE, 8'hfe});
    // reserved bits alone change nothing
    send(8'h0c, KEY_NULL, 8'h01, 8'h03);
    status(4'h0, {3'b110, POLL_ACTIVE, 8'hfe});
    // every polling code, upper parameter bits set to show they are unused
    for (int i = 0; i < 4; i++)
    begin
      send(8'h20, KEY_NULL, 8'h01, 8'hfc | 8'(i));
      status(4'h0, {3'b111, 2'(i), 8'hfe});
    end
    send(8'h10, KEY_NULL, 8'h01, 8'h03);
    status(4'h0, {3'b110, POLL_ACTIVE, 8'hfe});
    send(8'h02, KEY_NULL, 8'h01, 8'h00);
    status(4'h0, {3'b100, POLL_ACTIVE, 8'h00});
    // establishing again keeps the slot
    send(8'h00, KEY_ESTABLISH, 8'h01, 8'h00);
    chk("err", 16'h0000, {15'h0, err});
    status(4'h0, {3'b100, POLL_ACTIVE, 8'h00});
    // all ones asks for unlimited use: stored whole, no error
    send(8'h01, KEY_NULL, 8'h01, 8'hff);
    chk("err", 16'h0000, {15'h0, err});
    status(4'h0, {3'b110, POLL_ACTIVE, 8'hff});
    // fill all twelve slots
    for (int a = 2; a <= 12; a++)
    begin
      send(8'h00, KEY_ESTABLISH, 8'(a), 8'h00);
      chk("err", 16'h0000, {15'h0, err});
    end
    status(4'h4, {3'b100, POLL_ACTIVE, 8'h00});
    chk("full", 16'h0001, {15'h0, table_full_r});
    send(8'h00, KEY_ESTABLISH, 8'h0d, 8'h00);
    chk("err", 16'h0001, {15'h0, err});
    status(4'hc, 13'h0000);
    // state block storage at both ends of the range
    tsb_wr(4'hb, 6'h3f, 8'ha5);
    tsb_wr(4'h0, 6'h00, 8'h3c);
    tsb_rd(4'hb, 6'h3f, 8'ha5);
    tsb_rd(4'h0, 6'h00, 8'h3c);
    conclude();
  end
endmodule : testbench
